// >>> common/pmw_pkg.sv
`default_nettype none
package pmw_pkg;
	// Register byte offsets on the APB port
	localparam logic [7:0] PMW_CTRL_OFS = 8'h00;
	localparam logic [7:0] PMW_CLK_GATE_OFS = 8'h04;
	localparam logic [7:0] PMW_MODE_OFS = 8'h08;
	localparam logic [7:0] PMW_WAKE_EN_OFS = 8'h0C;
	localparam logic [7:0] PMW_WAKE_STS_OFS = 8'h10;
	localparam logic [7:0] PMW_IRQ_MASK_OFS = 8'h14;
	// Field positions and reset values
	localparam int PMW_CTRL_PD_ARM_BIT = 0;
	localparam logic [31:0] PMW_CLK_GATE_RST = 32'hFFFF_FFFF;
	localparam logic [31:0] PMW_WAKE_EN_RST = 32'h0000_0000;
	localparam logic [31:0] PMW_IRQ_MASK_RST = 32'h0000_0000;
	// Wake event groups, one status bit each
	localparam int PMW_EV_EXT_PIN = 0;
	localparam int PMW_EV_GPIO = 1;
	localparam int PMW_EV_TIMER = 2;
	localparam int PMW_EV_WDOG = 3;
	localparam int PMW_EV_RTC = 4;
	localparam int PMW_EV_CTS = 5;
	localparam int PMW_EV_RXD = 6;
	localparam int PMW_EV_FIFO_THR = 7;
	localparam int PMW_EV_FIFO_TOUT = 8;
	localparam int PMW_EV_ADDR = 9;
	localparam int PMW_EV_MAC = 10;
	localparam int PMW_EV_USBD = 11;
	localparam int PMW_EV_USBH = 12;
	localparam int PMW_EV_CAN = 13;
	localparam int PMW_EV_SDH = 14;
	localparam int PMW_EV_NUM = 15;
	// Source counts
	localparam int PMW_GPIO_W = 16;
	localparam int PMW_TIMERS = 6;
	localparam int PMW_SERIALS = 10;
	localparam int PMW_MACS = 2;
	localparam int PMW_CANS = 4;
	// Clock plan in MHz; dividers derive from the PLL rate
	localparam int PMW_PLL_MHZ = 300;
	localparam int PMW_CPU_MHZ = 300;
	localparam int PMW_DRAM_MHZ = 150;
	localparam int PMW_AHB_MHZ = 150;
	localparam int PMW_APB_MHZ = 75;
	localparam logic [2:0] PMW_CPU_DIV = 3'(PMW_PLL_MHZ / PMW_CPU_MHZ);
	localparam logic [2:0] PMW_DRAM_DIV = 3'(PMW_PLL_MHZ / PMW_DRAM_MHZ);
	localparam logic [2:0] PMW_AHB_DIV = 3'(PMW_PLL_MHZ / PMW_AHB_MHZ);
	localparam logic [2:0] PMW_APB_DIV = 3'(PMW_PLL_MHZ / PMW_APB_MHZ);
	// Timing: bus clock period and crystal start-up wait
	localparam int PMW_PCLK_PERIOD_NS = 20;
	localparam int PMW_XTAL_SETTLE_NS = 2000;
	localparam int PMW_XTAL_SETTLE_CYC =
		(PMW_XTAL_SETTLE_NS + PMW_PCLK_PERIOD_NS - 1) / PMW_PCLK_PERIOD_NS;
	// Mode states, one-hot
	typedef enum logic [4:0] {
		PMW_ST_NORMAL = 5'b00001,
		PMW_ST_IDLE = 5'b00010,
		PMW_ST_PDOWN = 5'b00100,
		PMW_ST_XTAL = 5'b01000,
		PMW_ST_RESTORE = 5'b10000
	} pmw_state_type;
	// Wake source inputs from peripherals and pins
	typedef struct packed {
		logic external_irq_pin_a;
		logic external_irq_pin_b;
		logic external_irq_pin_c;
		logic external_irq_pin_d;
		logic [PMW_GPIO_W-1:0] gpio_pin;
		logic [PMW_TIMERS-1:0] timer_irq;
		logic watchdog_unit_timeout_irq;
		logic rtc_alarm_irq;
		logic rtc_rel_alarm_irq;
		logic [PMW_SERIALS-1:0] serial_clear_to_send_in;
		logic [PMW_SERIALS-1:0] serial_receive_line;
		logic [PMW_SERIALS-1:0] serial_fifo_thr;
		logic [PMW_SERIALS-1:0] serial_fifo_tout;
		logic [PMW_SERIALS-1:0] automatic_address_detect_match;
		logic [PMW_MACS-1:0] ethernet_mac_unit_magic;
		logic high_speed_usb_device_ctrl_vbus;
		logic high_speed_usb_device_ctrl_reset;
		logic high_speed_usb_device_ctrl_resume;
		logic usb_host_connect;
		logic usb_host_disconnect;
		logic usb_host_remote_wake;
		logic [PMW_CANS-1:0] can_receive_line;
		logic sd_card_host_insert;
		logic sd_card_host_remove;
		logic sd_card_host_sdio_irq;
	} pmw_wake_src_type;
	// Clock and power controls to the clock tree
	typedef struct packed {
		logic cpu_clk_en;
		logic dram_clk_en;
		logic ahb_clk_en;
		logic apb_clk_en;
		logic high_speed_crystal_en;
		logic low_speed_crystal_en;
		logic sram_retain;
		logic [2:0] cpu_div;
		logic [2:0] dram_div;
		logic [2:0] ahb_div;
		logic [2:0] apb_div;
	} pmw_clk_ctrl_type;
endpackage : pmw_pkg
`default_nettype wire

// >>> logic/pmw_toggle_det.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_toggle_det #(
	parameter int WIDTH = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Sampled pins and per-bit toggle pulses
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] toggle
);
	logic [WIDTH-1:0] prev;
	logic primed;
	////////////////////////////////////////////////////////////////
	// Previous value; primed stops a false toggle right after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= '0;
			primed <= 1'b0;
		end else begin
			prev <= pin;
			primed <= 1'b1;
		end
	end
	// Either edge counts as a toggle
	assign toggle = primed ? (pin ^ prev) : '0;
endmodule : pmw_toggle_det
`default_nettype wire

// >>> logic/pmw_settle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_settle_timer #(
	parameter int WIDTH = 12,
	parameter int COUNT = 100
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Start pulse and one-cycle done pulse
	input wire logic start,
	output logic done
);
	localparam logic [WIDTH-1:0] LOAD = WIDTH'(COUNT);
	localparam logic [WIDTH-1:0] LAST = WIDTH'(1);
	logic [WIDTH-1:0] cnt;
	logic busy;
	////////////////////////////////////////////////////////////////
	// Count down from the load value; a new start restarts the wait
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
			busy <= 1'b0;
		end else if (start) begin
			cnt <= LOAD;
			busy <= 1'b1;
		end else if (busy) begin
			cnt <= cnt - LAST;
			if (cnt == LAST) begin
				busy <= 1'b0;
			end
		end
	end
	// Done in the last counted cycle
	assign done = busy && (cnt == LAST);
endmodule : pmw_settle_timer
`default_nettype wire

// >>> logic/pmw_power_ctrl.sv
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module pmw_power_ctrl #(
	parameter int N_PERIPH = 32,
	parameter int SETTLE_CYC = pmw_pkg::PMW_XTAL_SETTLE_CYC
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Processor core
	input wire logic cpu_wfi,
	input wire logic cpu_irq_req,
	// Wake sources
	input wire pmw_pkg::pmw_wake_src_type wake_src,
	// Clock tree controls
	output pmw_pkg::pmw_clk_ctrl_type clk_ctrl,
	output logic [N_PERIPH-1:0] periph_clk_en,
	// Interrupt
	output logic irq
);
	import pmw_pkg::*;

	// Mode sequencer state
	pmw_state_type state;
	pmw_state_type next_state;

	// Software-visible register copies
	logic pd_arm;
	logic [N_PERIPH-1:0] clk_gate;
	logic [PMW_EV_NUM-1:0] wake_en;
	logic [PMW_EV_NUM-1:0] wake_sts;
	logic [PMW_EV_NUM-1:0] irq_mask;

	// Event groups and the toggle pulses that feed them
	logic [PMW_EV_NUM-1:0] ev;
	logic [3:0] ext_tog;
	logic [PMW_GPIO_W-1:0] gpio_tog;
	logic [PMW_SERIALS-1:0] cts_tog;
	logic wake_hit;
	logic settle_done;

	// Bus decode helpers
	logic wr_en;
	logic setup_rd;
	logic addr_ok;
	logic [31:0] next_prdata;

	////////////////////////////////////////////////////////////////
	// Pin toggle detectors
	// Each ignores its first sampled cycle after reset, so no false wake
	pmw_toggle_det #(.WIDTH(4)) u_ext_tog (
		.pclk(pclk),
		.presetn(presetn),
		.pin({wake_src.external_irq_pin_d, wake_src.external_irq_pin_c,
			wake_src.external_irq_pin_b, wake_src.external_irq_pin_a}),
		.toggle(ext_tog)
	);

	pmw_toggle_det #(.WIDTH(PMW_GPIO_W)) u_gpio_tog (
		.pclk(pclk),
		.presetn(presetn),
		.pin(wake_src.gpio_pin),
		.toggle(gpio_tog)
	);

	pmw_toggle_det #(.WIDTH(PMW_SERIALS)) u_cts_tog (
		.pclk(pclk),
		.presetn(presetn),
		.pin(wake_src.serial_clear_to_send_in),
		.toggle(cts_tog)
	);

	////////////////////////////////////////////////////////////////
	// Fold every wake source into its event group
	always_comb begin
		ev = '0;
		// Pins wake on either edge; the toggle pulse lasts one cycle
		ev[PMW_EV_EXT_PIN] = |ext_tog;
		ev[PMW_EV_GPIO] = |gpio_tog;
		// Peripheral requests are levels held until software serves them; CTS pins wake on either edge
		ev[PMW_EV_TIMER] = |wake_src.timer_irq;
		ev[PMW_EV_WDOG] = wake_src.watchdog_unit_timeout_irq;
		ev[PMW_EV_RTC] = wake_src.rtc_alarm_irq | wake_src.rtc_rel_alarm_irq;
		ev[PMW_EV_CTS] = |cts_tog;
		// Receive lines idle high, so a low level means a start bit
		ev[PMW_EV_RXD] = ~&wake_src.serial_receive_line;
		ev[PMW_EV_FIFO_THR] = |wake_src.serial_fifo_thr;
		ev[PMW_EV_FIFO_TOUT] = |wake_src.serial_fifo_tout;
		ev[PMW_EV_ADDR] = |wake_src.automatic_address_detect_match;
		// Network, USB, CAN and card sources
		ev[PMW_EV_MAC] = |wake_src.ethernet_mac_unit_magic;
		ev[PMW_EV_USBD] = wake_src.high_speed_usb_device_ctrl_vbus
			| wake_src.high_speed_usb_device_ctrl_reset
			| wake_src.high_speed_usb_device_ctrl_resume;
		ev[PMW_EV_USBH] = wake_src.usb_host_connect | wake_src.usb_host_disconnect
			| wake_src.usb_host_remote_wake;
		ev[PMW_EV_CAN] = ~&wake_src.can_receive_line;
		ev[PMW_EV_SDH] = wake_src.sd_card_host_insert | wake_src.sd_card_host_remove
			| wake_src.sd_card_host_sdio_irq;
	end

	// Only enabled groups raise wake_hit, which ends power-down; idle also ends on cpu_irq_req
	assign wake_hit = |(ev & wake_en);

	////////////////////////////////////////////////////////////////
	// Mode sequencer
	always_comb begin
		next_state = state;
		case (state)
			PMW_ST_NORMAL: begin
				// Core's WFI picks idle, or power-down when armed
				if (cpu_wfi) begin
					next_state = pd_arm ? PMW_ST_PDOWN : PMW_ST_IDLE;
				end
			end
			PMW_ST_IDLE: begin
				// A pending core interrupt ends idle, as does an enabled event
				if (cpu_irq_req || wake_hit) begin
					next_state = PMW_ST_NORMAL;
				end
			end
			PMW_ST_PDOWN: begin
				// Only an enabled event leaves; the others just set status
				if (wake_hit) begin
					next_state = PMW_ST_XTAL;
				end
			end
			PMW_ST_XTAL: begin
				// Hold clocks off until the crystal has settled
				if (settle_done) begin
					next_state = PMW_ST_RESTORE;
				end
			end
			PMW_ST_RESTORE: begin
				// One cycle with bus clocks back before the core restarts
				next_state = PMW_ST_NORMAL;
			end
			default: begin
				// Illegal codes recover to normal rather than lock up
				next_state = PMW_ST_NORMAL;
			end
		endcase
	end

	// State register
	// Reset lands in normal mode with every clock running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= PMW_ST_NORMAL;
		end else begin
			state <= next_state;
		end
	end

	// Crystal start-up wait, started on the way out of power-down
	// Limitation: SETTLE_CYC must fit the 16-bit wait counter
	pmw_settle_timer #(.WIDTH(16), .COUNT(SETTLE_CYC)) u_settle (
		.pclk(pclk),
		.presetn(presetn),
		.start((state == PMW_ST_PDOWN) && wake_hit),
		.done(settle_done)
	);

	////////////////////////////////////////////////////////////////
	// Clock tree controls, registered per mode
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_ctrl <= '{cpu_clk_en: 1'b1, dram_clk_en: 1'b1, ahb_clk_en: 1'b1,
				apb_clk_en: 1'b1, high_speed_crystal_en: 1'b1,
				low_speed_crystal_en: 1'b1, sram_retain: 1'b0,
				cpu_div: PMW_CPU_DIV, dram_div: PMW_DRAM_DIV,
				ahb_div: PMW_AHB_DIV, apb_div: PMW_APB_DIV};
		end else begin
			// Ratios never change; only the enables and retention follow the mode
			clk_ctrl.cpu_div <= PMW_CPU_DIV;
			clk_ctrl.dram_div <= PMW_DRAM_DIV;
			clk_ctrl.ahb_div <= PMW_AHB_DIV;
			clk_ctrl.apb_div <= PMW_APB_DIV;
			// The low-speed crystal keeps running in every mode
			clk_ctrl.low_speed_crystal_en <= 1'b1;
			clk_ctrl.cpu_clk_en <= (next_state == PMW_ST_NORMAL);
			// Bus clocks run in normal, idle and restore only
			clk_ctrl.dram_clk_en <= next_state[0] | next_state[1] | next_state[4];
			clk_ctrl.ahb_clk_en <= next_state[0] | next_state[1] | next_state[4];
			clk_ctrl.apb_clk_en <= next_state[0] | next_state[1] | next_state[4];
			// Crystal restarts as soon as a wake is seen
			clk_ctrl.high_speed_crystal_en <= (next_state != PMW_ST_PDOWN);
			// Retention covers power-down and the crystal wait
			clk_ctrl.sram_retain <= (next_state == PMW_ST_PDOWN)
				|| (next_state == PMW_ST_XTAL);
		end
	end

	// Per-peripheral gates; everything off in power-down and start-up
	// Limitation: a gate written in power-down takes effect at restore
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_clk_en <= PMW_CLK_GATE_RST[N_PERIPH-1:0];
		end else if (next_state[2] || next_state[3]) begin
			periph_clk_en <= '0;
		end else begin
			periph_clk_en <= clk_gate;
		end
	end

	////////////////////////////////////////////////////////////////
	// APB decode: zero wait states, read data caught in setup phase
	// Catching it in setup lets it stand through the whole access phase
	assign wr_en = psel && penable && pwrite && addr_ok;
	assign setup_rd = psel && !penable && !pwrite;
	assign pready = 1'b1;
	// Unmapped addresses answer with an error and no effect
	assign pslverr = psel && penable && !addr_ok;

	always_comb begin
		if (paddr == PMW_CTRL_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr == PMW_CLK_GATE_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr == PMW_MODE_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr == PMW_WAKE_EN_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr == PMW_WAKE_STS_OFS) begin
			addr_ok = 1'b1;
		end else if (paddr == PMW_IRQ_MASK_OFS) begin
			addr_ok = 1'b1;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// Read multiplexer
	always_comb begin
		next_prdata = '0;
		if (paddr == PMW_CTRL_OFS) begin
			next_prdata[PMW_CTRL_PD_ARM_BIT] = pd_arm;
		end else if (paddr == PMW_CLK_GATE_OFS) begin
			next_prdata[N_PERIPH-1:0] = clk_gate;
		end else if (paddr == PMW_MODE_OFS) begin
			next_prdata[4:0] = state;
		end else if (paddr == PMW_WAKE_EN_OFS) begin
			next_prdata[PMW_EV_NUM-1:0] = wake_en;
		end else if (paddr == PMW_WAKE_STS_OFS) begin
			next_prdata[PMW_EV_NUM-1:0] = wake_sts;
		end else if (paddr == PMW_IRQ_MASK_OFS) begin
			next_prdata[PMW_EV_NUM-1:0] = irq_mask;
		end
	end

	// Read data register, stable through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= '0;
		end else if (setup_rd) begin
			prdata <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////
	// Power-down arm bit; hardware clears it once power-down ends
	// A software write in the restore cycle wins over the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pd_arm <= 1'b0;
		end else if (wr_en && (paddr == PMW_CTRL_OFS)) begin
			pd_arm <= pwdata[PMW_CTRL_PD_ARM_BIT];
		end else if (state == PMW_ST_RESTORE) begin
			pd_arm <= 1'b0;
		end
	end

	// Peripheral clock gate register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_gate <= PMW_CLK_GATE_RST[N_PERIPH-1:0];
		end else if (wr_en && (paddr == PMW_CLK_GATE_OFS)) begin
			clk_gate <= pwdata[N_PERIPH-1:0];
		end
	end

	// Wake enable and interrupt mask registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_en <= PMW_WAKE_EN_RST[PMW_EV_NUM-1:0];
			irq_mask <= PMW_IRQ_MASK_RST[PMW_EV_NUM-1:0];
		end else if (wr_en && (paddr == PMW_WAKE_EN_OFS)) begin
			wake_en <= pwdata[PMW_EV_NUM-1:0];
		end else if (wr_en && (paddr == PMW_IRQ_MASK_OFS)) begin
			irq_mask <= pwdata[PMW_EV_NUM-1:0];
		end
	end

	// Sticky wake status; a new event beats a write-one clear
	// Status collects in every mode, whatever the wake enables say
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_sts <= '0;
		end else if (wr_en && (paddr == PMW_WAKE_STS_OFS)) begin
			wake_sts <= (wake_sts & ~pwdata[PMW_EV_NUM-1:0]) | ev;
		end else begin
			wake_sts <= wake_sts | ev;
		end
	end

	// Level interrupt while any unmasked status bit stands
	// Registered so a decode ripple cannot glitch the line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(wake_sts & irq_mask);
		end
	end
endmodule : pmw_power_ctrl
`default_nettype wire

// >>> tb/pmw_power_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_checker
	import pmw_pkg::*;
#(
	parameter int N_PERIPH = 32
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Core and clock tree
	input wire logic cpu_wfi,
	input wire pmw_pkg::pmw_clk_ctrl_type clk_ctrl,
	input wire logic [N_PERIPH-1:0] periph_clk_en
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	////////////////
	property p_div_fixed;
		clk_ctrl.cpu_div == 3'h1 && clk_ctrl.dram_div == 3'h2
			&& clk_ctrl.ahb_div == 3'h2 && clk_ctrl.apb_div == 3'h4;
	endproperty
	a_div_fixed: assert property (p_div_fixed)
		else $error("clock ratio wrong");
	// Retention without fast crystal means power-down
	property p_pdown;
		clk_ctrl.sram_retain && !clk_ctrl.high_speed_crystal_en |-> clk_ctrl.low_speed_crystal_en
			&& !(clk_ctrl.cpu_clk_en || clk_ctrl.dram_clk_en || clk_ctrl.ahb_clk_en
			|| clk_ctrl.apb_clk_en) && periph_clk_en == '0;
	endproperty
	a_pdown: assert property (p_pdown)
		else $error("power-down clock left on");
	property p_wfi_halt;
		clk_ctrl.cpu_clk_en && cpu_wfi |=> !clk_ctrl.cpu_clk_en;
	endproperty
	a_wfi_halt: assert property (p_wfi_halt)
		else $error("cpu clock kept after wfi");
	// Idle keeps all bus clocks, power-down none
	property p_idle_bus;
		clk_ctrl.cpu_clk_en && cpu_wfi |=> clk_ctrl.ahb_clk_en != clk_ctrl.sram_retain
			&& clk_ctrl.dram_clk_en == clk_ctrl.ahb_clk_en
			&& clk_ctrl.apb_clk_en == clk_ctrl.ahb_clk_en;
	endproperty
	a_idle_bus: assert property (p_idle_bus)
		else $error("bus clocks wrong after wfi");
	property p_restart;
		$rose(clk_ctrl.high_speed_crystal_en) |-> ##[1:200] clk_ctrl.cpu_clk_en;
	endproperty
	a_restart: assert property (p_restart)
		else $error("cpu not restarted after crystal");
	// Gate register reaches the peripheral enables one cycle after the write lands
	property p_gate;
		psel && penable && pwrite && paddr == PMW_CLK_GATE_OFS
			|=> ##1 !clk_ctrl.cpu_clk_en || periph_clk_en == $past(pwdata, 2);
	endproperty
	a_gate: assert property (p_gate)
		else $error("peripheral gates not updated");
	property p_refuse;
		psel && penable && paddr > PMW_IRQ_MASK_OFS |-> pslverr;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("unmapped access accepted");
	// Zero wait states: every access phase completes at once
	property p_ready;
		psel && penable |-> pready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("access phase stalled");
	// Unmapped reads answer with zero data
	property p_rd_refuse;
		psel && penable && !pwrite && paddr > PMW_IRQ_MASK_OFS |-> prdata == 32'h0000_0000;
	endproperty
	a_rd_refuse: assert property (p_rd_refuse)
		else $error("unmapped read returned data");
endmodule : pmw_checker
bind pmw_power_ctrl pmw_checker #(.N_PERIPH(N_PERIPH)) u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_wfi(cpu_wfi), .clk_ctrl(clk_ctrl),
	.periph_clk_en(periph_clk_en));
`default_nettype wire

// >>> tb/pmw_src_model.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_src_model
	import pmw_pkg::*;
(
	// Clock
	input wire logic pclk,
	// Core side
	output logic cpu_wfi,
	output logic cpu_irq_req,
	// Wake sources
	output pmw_pkg::pmw_wake_src_type wake_src
);
	// Receive lines idle high so only a real low counts
	localparam pmw_wake_src_type QUIET =
		'{serial_receive_line: '1, can_receive_line: '1, default: '0};
	initial begin
		cpu_wfi = 1'b0;
		cpu_irq_req = 1'b0;
		wake_src = QUIET;
	end
	// The core halts only through a one-cycle wait pulse
	task automatic wfi;
		@(posedge pclk);
		cpu_wfi <= 1'b1;
		@(posedge pclk);
		cpu_wfi <= 1'b0;
	endtask : wfi
	task automatic set_irq(input logic v);
		@(posedge pclk);
		cpu_irq_req <= v;
	endtask : set_irq
	// One event of group k; held two cycles, then back to quiet
	task automatic fire(input int k, input int unsigned r);
		pmw_wake_src_type w;
		w = QUIET;
		case (k)
			0: w.external_irq_pin_c = 1'b1;
			1: w.gpio_pin[r % 16] = 1'b1;
			2: w.timer_irq[r % 6] = 1'b1;
			3: w.watchdog_unit_timeout_irq = 1'b1;
			4: w.rtc_rel_alarm_irq = 1'b1;
			5: w.serial_clear_to_send_in[r % 10] = 1'b1;
			6: w.serial_receive_line[r % 10] = 1'b0;
			7: w.serial_fifo_thr[r % 10] = 1'b1;
			8: w.serial_fifo_tout[r % 10] = 1'b1;
			9: w.automatic_address_detect_match[r % 10] = 1'b1;
			10: w.ethernet_mac_unit_magic[r % 2] = 1'b1;
			11: w.high_speed_usb_device_ctrl_resume = 1'b1;
			12: w.usb_host_remote_wake = 1'b1;
			13: w.can_receive_line[r % 4] = 1'b0;
			default: w.sd_card_host_sdio_irq = 1'b1;
		endcase
		@(posedge pclk);
		wake_src <= w;
		repeat (2) @(posedge pclk);
		wake_src <= QUIET;
		repeat (3) @(posedge pclk);
	endtask : fire
endmodule : pmw_src_model
`default_nettype wire

// >>> tb/pmw_power_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module pmw_power_ctrl_test;
	import pmw_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic cpu_wfi;
	logic cpu_irq_req;
	pmw_wake_src_type wake_src;
	pmw_clk_ctrl_type clk_ctrl;
	logic [31:0] periph_clk_en;
	logic irq;
	logic [32:0] exp_q[$];
	int err_total = 0;
	int samples_checked = 0;
	// 50 MHz bus clock
	always #10 pclk = ~pclk;
	pmw_src_model src (.pclk(pclk), .cpu_wfi(cpu_wfi), .cpu_irq_req(cpu_irq_req),
		.wake_src(wake_src));
	// Short crystal wait keeps the run brief
	pmw_power_ctrl #(.N_PERIPH(32), .SETTLE_CYC(3)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_wfi(cpu_wfi),
		.cpu_irq_req(cpu_irq_req), .wake_src(wake_src), .clk_ctrl(clk_ctrl),
		.periph_clk_en(periph_clk_en), .irq(irq));
	////////////////
	task automatic check(input string name, input logic [32:0] seen, input logic [32:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("BAD %s exp %h seen %h", name, exp, seen);
			err_total++;
		end
	endtask : check
	task automatic stop_test;
		$display("compared %0d, mismatched %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : stop_test
	// One APB transfer; e holds the expected error flag and read data
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [32:0] e);
		int n;
		exp_q.push_back(e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			err_total++;
			stop_test();
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, {1'b0, e});
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 33'h0_0000_0000);
	endtask : wr
	// Each completed transfer is held against the oldest note
	always @(posedge pclk) begin
		if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("note", 33'h0_0000_0000, 33'h1_FFFF_FFFF);
			end else begin
				check("apb", {pslverr, pwrite ? 32'h0000_0000 : prdata}, exp_q.pop_front());
			end
		end
	end
	////////////////
	initial begin
		pmw_clk_ctrl_type run;
		pmw_clk_ctrl_type pd;
		pmw_clk_ctrl_type idle_exp;
		logic [31:0] v;
		int unsigned r;
		int n;
		run = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 3'h1, 3'h2, 3'h2, 3'h4};
		pd = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 3'h1, 3'h2, 3'h2, 3'h4};
		// Idle: core clock halted, everything else as in normal mode
		idle_exp = run;
		idle_exp.cpu_clk_en = 1'b0;
		void'($urandom(94858));
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		check("clk", 33'(clk_ctrl), 33'(run));
		rd(PMW_MODE_OFS, 32'h0000_0001);
		rd(PMW_CLK_GATE_OFS, 32'hFFFF_FFFF);
		rd(PMW_WAKE_EN_OFS, 32'h0000_0000);
		rd(PMW_IRQ_MASK_OFS, 32'h0000_0000);
		$display("reset test over");
		v = $urandom;
		wr(PMW_CLK_GATE_OFS, v);
		rd(PMW_CLK_GATE_OFS, v);
		check("periph", 33'(periph_clk_en), 33'(v));
		apb(1'b1, 8'h40, ~v, {1'b1, 32'h0000_0000});
		apb(1'b0, 8'h40, 32'h0000_0000, {1'b1, 32'h0000_0000});
		rd(PMW_CLK_GATE_OFS, v);
		$display("gate test over");
		src.wfi();
		@(posedge pclk);
		check("idle", 33'(clk_ctrl), 33'(idle_exp));
		rd(PMW_MODE_OFS, 32'h0000_0002);
		src.set_irq(1'b1);
		repeat (2) @(posedge pclk);
		src.set_irq(1'b0);
		rd(PMW_MODE_OFS, 32'h0000_0001);
		$display("idle test over");
		for (int k = 0; k < PMW_EV_NUM; k++) begin
			r = $urandom;
			wr(PMW_WAKE_EN_OFS, 32'h1 << k);
			wr(PMW_IRQ_MASK_OFS, 32'(k % 2) << k);
			wr(PMW_CTRL_OFS, 32'h0000_0001);
			src.wfi();
			@(posedge pclk);
			check("pd", {|periph_clk_en, clk_ctrl}, {1'b0, pd});
			if (k == 0) begin
				src.fire(3, r);
				rd(PMW_MODE_OFS, 32'h0000_0004);
				wr(PMW_WAKE_STS_OFS, 32'h0000_0008);
			end
			src.fire(k, r);
			for (n = 0; clk_ctrl.cpu_clk_en !== 1'b1 && n < 300; n++) @(posedge pclk);
			if (n == 300) begin
				err_total++;
				stop_test();
			end
			check("wake", 33'(clk_ctrl), 33'(run));
			rd(PMW_CTRL_OFS, 32'h0000_0000);
			rd(PMW_WAKE_STS_OFS, 32'h1 << k);
			check("irq", 33'(irq), 33'(k % 2));
			wr(PMW_WAKE_STS_OFS, 32'h1 << k);
			rd(PMW_WAKE_STS_OFS, 32'h0000_0000);
			check("irq", 33'(irq), 33'h0_0000_0000);
		end
		$display("wake test over");
		stop_test();
	end
	// Cut a hung run short
	initial begin
		repeat (100000) @(posedge pclk);
		err_total++;
		stop_test();
	end
endmodule : pmw_power_ctrl_test
`default_nettype wire
